// File: design/reset_pulse.sv
/*
 * stretches a start strobe into a pulse of LEN enabled cycles.
 * assumes start is synchronous to mclk; starts during a pulse are dropped.
 */
`timescale 1ns/1ps
module reset_pulse #(
    parameter int unsigned LEN = 3750
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    output logic active_q
);
    localparam int unsigned W = (LEN > 1) ? $clog2(LEN) : 1;

    logic [W-1:0] left_q; // cycles still to hold after this one
    logic last; // final cycle of the pulse

    assign last = active_q & (left_q == '0);

    // pulse length counter; a running pulse is never restarted
    always_ff @(posedge mclk) begin
        if (rst) begin
            active_q <= 1'b0;
            left_q <= '0;
        end else if (ce) begin
            if (!active_q && start) begin
                active_q <= 1'b1;
                left_q <= W'(LEN - 1);
            end else if (last) begin
                active_q <= 1'b0;
            end else if (active_q) begin
                left_q <= left_q - W'(1);
            end
        end
    end
endmodule // reset_pulse

// File: design/step_divider.sv
/*
 * free-running divider giving a one-cycle tick every DIV enabled cycles.
 * assumes mclk is the oscillator-derived clock and ce gates all state.
 */
`timescale 1ns/1ps
module step_divider #(
    parameter int unsigned DIV = 16384
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    output logic tick
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

    logic [W-1:0] cnt_q; // cycles since last tick
    logic [W-1:0] cnt_d;
    logic wrap; // last cycle of a period

    assign wrap = (cnt_q == W'(DIV - 1));
    assign cnt_d = wrap ? '0 : cnt_q + W'(1);
    // tick only in an enabled cycle, so a frozen block never steps
    assign tick = ce & wrap;

    // period counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end
endmodule // step_divider

// File: design/windowed_watchdog.sv
/*
 * windowed watchdog: 7-bit downcounter, window compare, reset pin pulse.
 * assumes mclk is the oscillator-derived clock, option settings are
 * steady levels from same-clock logic, and halt_exec is a one-cycle
 * strobe from the processor on mclk.
 */
// Implementation choices: the register offsets and the address-and-strobe port.
// What this block does
// R1 - counter steps down every 16384 clock cycles
// R2 - software picks timeout in 64 steps
// R3 - active, 40h to 3Fh starts reset
// R4 - watchdog reset drives pin low ~30us
// R5 - refresh above window value forces reset
// R6 - counter sits in control bits 6:0
// R7 - no reset unless activation bit set
// R8 - option picks hardware or software activation
// R9 - option enables reset on halt instruction
// R10 - control write loads count, sets activate
`timescale 1ns/1ps
module windowed_watchdog
    import windowed_watchdog_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES,
    parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire reg_req_s bus_req,
    input wire logic opt_hw_activate,
    input wire logic opt_halt_reset,
    input wire logic halt_exec,
    output logic [7:0] rd_data_q,
    output logic reset_pin_out_q,
    output logic reset_pin_oe,
    output logic watchdog_activate_bit
);

    // state
    logic [CNT_W-1:0] counter_q; // the downcounter
    logic [CNT_W-1:0] counter_d;
    logic [CNT_W-1:0] window_q; // refresh window limit
    logic [CNT_W-1:0] window_d;
    logic act_q; // activation, set only
    logic act_d;
    logic halt_opt_q; // halt reset option, caught after reset
    logic halt_opt_d;
    logic started_q; // options already sampled
    logic [7:0] rd_data_d;

    // decode, only in enabled cycles
    logic wr_ctrl;
    logic wr_win;
    logic rd_ctrl;
    logic rd_win;
    logic tick; // one counter step due
    logic top_fall; // counter_top_bit drops this cycle
    logic bad_refresh; // reload while above the window
    logic halt_hit; // halt executed with option set
    logic fire; // start a reset pulse

    assign wr_ctrl = ce & bus_req.wr & (bus_req.addr == CTRL_ADDR);
    assign wr_win = ce & bus_req.wr & (bus_req.addr == WIN_ADDR);
    assign rd_ctrl = ce & bus_req.rd & (bus_req.addr == CTRL_ADDR);
    assign rd_win = ce & bus_req.rd & (bus_req.addr == WIN_ADDR);

    // step divider, runs whether or not the watchdog is active
    step_divider #(
        .DIV(TICK_DIV)
    ) u_div (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .tick(tick) // R1
    );

    // a write wins over a step in the same cycle; count wraps 00 to 7f
    assign counter_d = wr_ctrl ? bus_req.wdata[CNT_W-1:0] : // R10 R2
                       tick ? counter_q - 7'h01 : // R1
                       counter_q;
    assign window_d = wr_win ? bus_req.wdata[CNT_W-1:0] : window_q;

    // any drop of the top bit counts, so loading a value below 40h
    // while active also expires at once
    assign top_fall = counter_q[TOP_BIT] & ~counter_d[TOP_BIT]; // R3
    // compare uses the count before the reload
    assign bad_refresh = wr_ctrl & (counter_q > window_q); // R5
    assign halt_hit = ce & halt_exec & halt_opt_q; // R9
    // every cause is gated by activation
    assign fire = act_q & (top_fall | bad_refresh | halt_hit); // R7

    // options sampled in the first enabled cycle after reset release
    assign act_d = !started_q ? (opt_hw_activate | (wr_ctrl // R8
                   & bus_req.wdata[ACT_BIT])) :
                   act_q | (wr_ctrl & bus_req.wdata[ACT_BIT]); // R10
    assign halt_opt_d = !started_q ? opt_halt_reset : halt_opt_q;

    // read mux; unmapped index reads zero
    assign rd_data_d = rd_ctrl ? {act_q, counter_q} : // R6
                       rd_win ? {1'b0, window_q} :
                       8'h00;

    // counter and window
    always_ff @(posedge mclk) begin
        if (rst) begin
            counter_q <= CNT_RST;
            window_q <= WIN_RST;
        end else if (ce) begin
            counter_q <= counter_d;
            window_q <= window_d;
        end
    end

    // activation and option capture
    always_ff @(posedge mclk) begin
        if (rst) begin
            act_q <= 1'b0;
            halt_opt_q <= 1'b0;
            started_q <= 1'b0;
        end else if (ce) begin
            act_q <= act_d;
            halt_opt_q <= halt_opt_d;
            started_q <= 1'b1;
        end
    end

    // read data stands one cycle only; frozen while ce is low
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data_q <= 8'h00;
        end else if (ce) begin
            rd_data_q <= rd_data_d;
        end
    end

    // pin only ever pulled low, open-drain style
    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_pin_out_q <= 1'b0;
        end else begin
            reset_pin_out_q <= 1'b0;
        end
    end

    assign watchdog_activate_bit = act_q;

    // reset pin pulse of fixed length
    reset_pulse #(
        .LEN(PULSE_LEN)
    ) u_pulse (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .start(fire),
        .active_q(reset_pin_oe) // R4
    );

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_r1;
        ce && !wr_ctrl && !tick |=> $stable(counter_q);
    endproperty
    a_r1: assert property (p_r1) else $error("count moved off a step"); // R1

    property p_r1b;
        tick && !wr_ctrl |=> counter_q == $past(counter_q) - 7'h01;
    endproperty
    a_r1b: assert property (p_r1b) else $error("step not by one"); // R1

    property p_r2;
        wr_ctrl |=> counter_q[5:0] == $past(bus_req.wdata[5:0]);
    endproperty
    a_r2: assert property (p_r2) else $error("low count bits not loaded"); // R2

    property p_r3;
        act_q && tick && !wr_ctrl && counter_q == EXPIRE_FROM
            && !reset_pin_oe |=> reset_pin_oe;
    endproperty
    a_r3: assert property (p_r3) else $error("expiry gave no reset"); // R3

    property p_r4;
        $rose(reset_pin_oe) |-> reset_pin_oe[*8] ##0 !reset_pin_out_q;
    endproperty
    a_r4: assert property (p_r4) else $error("reset pulse too short"); // R4

    property p_r5;
        wr_ctrl && act_q && !reset_pin_oe
            && counter_q > window_q |=> reset_pin_oe;
    endproperty
    a_r5: assert property (p_r5) else $error("early refresh not caught"); // R5

    property p_r6;
        rd_ctrl |=> rd_data_q == {$past(act_q), $past(counter_q)};
    endproperty
    a_r6: assert property (p_r6) else $error("control read wrong"); // R6

    property p_r7;
        !act_q && !reset_pin_oe |=> !reset_pin_oe;
    endproperty
    a_r7: assert property (p_r7) else $error("reset while inactive"); // R7

    property p_r8;
        ce && !started_q && !bus_req.wr
            |=> act_q == $past(opt_hw_activate);
    endproperty
    a_r8: assert property (p_r8) else $error("start-up activation wrong"); // R8

    property p_r9;
        ce && halt_exec && halt_opt_q && act_q && !reset_pin_oe
            |=> reset_pin_oe;
    endproperty
    a_r9: assert property (p_r9) else $error("halt gave no reset"); // R9

    property p_r10;
        wr_ctrl && bus_req.wdata[ACT_BIT] |=> act_q;
    endproperty
    a_r10: assert property (p_r10) else $error("activate bit not set"); // R10

    c_expire: cover property (act_q && top_fall && tick);
    c_early: cover property (act_q && bad_refresh);
    c_halt: cover property (act_q && halt_hit);
    c_good: cover property (act_q && wr_ctrl && !bad_refresh
                            && !top_fall);

endmodule // windowed_watchdog

// File: design/windowed_watchdog_pkg.sv
/*
 * shared constants and bus carrier for the windowed watchdog.
 * assumes a single 125 mhz clock (mclk) and a synchronous reset.
 */
package windowed_watchdog_pkg;

    // clock figure
    localparam int unsigned CLK_PERIOD_NS = 8;

    // register map, index of each register on the plain port
    localparam int unsigned ADDR_W = 2;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 2'h0;
    localparam logic [ADDR_W-1:0] WIN_ADDR = 2'h1;

    // field layout of watchdog_control_reg
    localparam int unsigned CNT_W = 7;
    localparam int unsigned ACT_BIT = 7;
    localparam int unsigned TOP_BIT = 6;

    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 7'h7f;
    localparam logic [CNT_W-1:0] WIN_RST = 7'h7f;

    // the count that expires: stepping from here drops the top bit
    localparam logic [CNT_W-1:0] EXPIRE_FROM = 7'h40;

    // oscillator_div_clock cycles per counter step
    localparam int unsigned TICK_CYCLES = 16384;

    // reset pin pulse, typical length
    localparam int unsigned PULSE_NS = 30000;
    localparam int unsigned PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;

    // one register bus request, all signals of one cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr; // register index
        logic [7:0] wdata; // write data
        logic wr; // write strobe
        logic rd; // read strobe
    } reg_req_s;

endpackage

// File: testbench/windowed_watchdog_bench.sv
/*
 * self-checking bench for the windowed watchdog, scenario tasks.
 * assumes the design package and a short divider and pulse length.
 */
`timescale 1ns/1ps
module windowed_watchdog_bench
    import windowed_watchdog_pkg::*;
;
    localparam int TICK = 16; // shortened step divider
    localparam int PLEN = 10; // shortened reset pulse
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1; // clock enable, running except while t_freeze holds it low
    reg_req_s bus_req = '0;
    logic opt_hw_activate = 1'b0;
    logic opt_halt_reset = 1'b0;
    logic halt_exec = 1'b0;
    logic [7:0] rd_data_q;
    logic reset_pin_out_q;
    logic reset_pin_oe;
    logic watchdog_activate_bit;
    int bad_count = 0;
    int checks_done = 0;
    logic [7:0] v; // last read value
    int c; // cycle count of the last wait

    windowed_watchdog #(.TICK_DIV(TICK), .PULSE_LEN(PLEN)) i_dut (
        .mclk(mclk), .rst(rst), .ce(ce), .bus_req(bus_req),
        .opt_hw_activate(opt_hw_activate),
        .opt_halt_reset(opt_halt_reset), .halt_exec(halt_exec),
        .rd_data_q(rd_data_q), .reset_pin_out_q(reset_pin_out_q),
        .reset_pin_oe(reset_pin_oe),
        .watchdog_activate_bit(watchdog_activate_bit));

    // free-running 125 mhz clock
    always #4 mclk = ~mclk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one write cycle, returns just after the taking edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) bus_req <= '0;
        #1;
    endtask

    // one read cycle, data stands only in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge mclk)
            bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk) bus_req <= '0;
        #1 v = rd_data_q;
    endtask

    // options are picked up at the first edge after release
    task automatic do_reset(input logic hw, input logic halt);
        @(posedge mclk);
        opt_hw_activate <= hw;
        opt_halt_reset <= halt;
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    // bounded wait for the reset pin drive
    task automatic wait_oe(input int n);
        c = 0;
        while (reset_pin_oe !== 1'b1 && c < n) begin
            @(posedge mclk);
            #1 c++;
        end
    endtask

    task automatic halt_pulse();
        @(posedge mclk) halt_exec <= 1'b1;
        @(posedge mclk) halt_exec <= 1'b0;
        #1;
    endtask

    task automatic t_reset_vals();
        do_reset(1'b0, 1'b0);
        chk({6'h0, reset_pin_oe, reset_pin_out_q}, 8'h00);
        chk({7'h0, watchdog_activate_bit}, 8'h00);
        rd(CTRL_ADDR);
        chk(v, 8'h7f);
        rd(WIN_ADDR);
        chk(v, 8'h7f);
        rd(2'h2);
        chk(v, 8'h00);
    endtask

    // back-to-back reads spot two counter steps, spacing must be one tick
    task automatic t_step();
        int e1;
        int e2;
        logic [7:0] last;
        e1 = -1;
        e2 = -1;
        wr(CTRL_ADDR, 8'h70);
        rd(CTRL_ADDR);
        chk(v, 8'h70);
        last = v;
        @(posedge mclk) bus_req <= '{addr: CTRL_ADDR, wdata: 8'h00,
                                     wr: 1'b0, rd: 1'b1};
        for (int i = 0; i < 3 * TICK && e2 < 0; i++) begin
            @(posedge mclk);
            #1;
            if (i > 0 && rd_data_q !== last) begin
                chk(rd_data_q, last - 8'h01);
                if (e1 < 0) e1 = i;
                else e2 = i;
            end
            last = rd_data_q;
        end
        bus_req <= '0;
        chk(8'(e2 - e1), 8'(TICK));
    endtask

    // expiry delay follows the loaded count, then a full pulse
    task automatic t_expire(input logic [7:0] t);
        int lo;
        int hi;
        lo = (int'(t) - 'h40) * TICK;
        hi = (int'(t) - 'h3f) * TICK + 2;
        do_reset(1'b0, 1'b0);
        wr(CTRL_ADDR, 8'h80 | t);
        chk({7'h0, watchdog_activate_bit}, 8'h01);
        wait_oe(hi + 4);
        chk({7'h0, reset_pin_oe}, 8'h01);
        chk({7'h0, c >= lo && c <= hi}, 8'h01);
        c = 0;
        while (reset_pin_oe === 1'b1 && c < 4 * PLEN) begin
            @(posedge mclk);
            #1 c++;
        end
        chk(8'(c), 8'(PLEN));
    endtask

    // while not activated neither window nor expiry may fire
    task automatic t_inactive();
        do_reset(1'b0, 1'b0);
        wr(WIN_ADDR, 8'h50);
        wr(CTRL_ADDR, 8'h60);
        wr(CTRL_ADDR, 8'h41);
        wait_oe(4 * TICK);
        chk({7'h0, reset_pin_oe}, 8'h00);
    endtask

    task automatic t_window();
        do_reset(1'b0, 1'b0);
        wr(CTRL_ADDR, 8'hff);
        wait_oe(3);
        chk({7'h0, reset_pin_oe}, 8'h00);
        wr(WIN_ADDR, 8'hd0);
        rd(WIN_ADDR);
        chk(v, 8'h50);
        wr(CTRL_ADDR, 8'hff);
        wait_oe(3);
        chk({7'h0, reset_pin_oe}, 8'h01);
    endtask

    // clock enable low freezes count and divider, drops the write
    task automatic t_freeze();
        do_reset(1'b0, 1'b0);
        wr(CTRL_ADDR, 8'h70);
        @(posedge mclk) ce <= 1'b0;
        wr(CTRL_ADDR, 8'h10); // strobe lands in a frozen cycle
        repeat (3 * TICK) @(posedge mclk);
        @(posedge mclk) ce <= 1'b1;
        rd(CTRL_ADDR);
        chk(v, 8'h70);
    endtask

    // start-up activation and halt option, in three of the four pairings
    task automatic t_options();
        do_reset(1'b1, 1'b0);
        chk({7'h0, watchdog_activate_bit}, 8'h01);
        halt_pulse();
        wait_oe(3);
        chk({7'h0, reset_pin_oe}, 8'h00);
        do_reset(1'b0, 1'b1);
        halt_pulse();
        wait_oe(3);
        chk({7'h0, reset_pin_oe}, 8'h00);
        do_reset(1'b1, 1'b1);
        halt_pulse();
        wait_oe(3);
        chk({7'h0, reset_pin_oe}, 8'h01);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        t_reset_vals();
        t_step();
        t_expire(8'h41);
        t_expire(8'h43);
        t_inactive();
        t_window();
        t_options();
        t_freeze();
        give_verdict();
    end

    // hang guard, well above the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end
endmodule // windowed_watchdog_bench
